// ### pkg/rpi_pkg.sv
package rpi_pkg;

   // Register byte offsets
   localparam logic [7:0] RPI_OFF_DECODE     = 8'h00;
   localparam logic [7:0] RPI_OFF_MASK       = 8'h04;
   localparam logic [7:0] RPI_OFF_STATUS     = 8'h08;
   localparam logic [7:0] RPI_OFF_FIFO_RD1   = 8'h0c;
   localparam logic [7:0] RPI_OFF_FIFO_RD2   = 8'h10;
   localparam logic [7:0] RPI_OFF_MSI_BASE1  = 8'h14;
   localparam logic [7:0] RPI_OFF_MSI_BASE2  = 8'h18;
   localparam logic [7:0] RPI_OFF_DECODE2    = 8'h1c;
   localparam logic [7:0] RPI_OFF_DECODE2_MK = 8'h20;
   localparam logic [7:0] RPI_OFF_MSI_DEC1   = 8'h24;
   localparam logic [7:0] RPI_OFF_MSI_DEC2   = 8'h28;
   localparam logic [7:0] RPI_OFF_MSI_MK1    = 8'h2c;
   localparam logic [7:0] RPI_OFF_MSI_MK2    = 8'h30;

   // Field positions
   localparam int RPI_BIT_INTX       = 16;
   localparam int RPI_BIT_MSI        = 17;
   localparam int RPI_BIT_NOT_EMPTY  = 18;
   localparam int RPI_BIT_OVERFLOW   = 19;
   localparam int RPI_BIT_POP        = 31;
   localparam int RPI_BIT_FIFO_MSI   = 17;
   localparam int RPI_BIT_FIFO_ASRT  = 16;
   localparam int RPI_MSI_WIN_BITS   = 12;
   localparam int RPI_VEC_BITS       = 6;

   // Reset values
   localparam logic [31:0] RPI_RST_ZERO = 32'h0000_0000;
   localparam logic [31:0] RPI_RST_MASK = 32'h0000_0000;

   // AXI responses
   localparam logic [1:0] RPI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RPI_RESP_SLVERR = 2'h2;

   // FIFO entry kinds
   typedef enum logic [1:0] {
      RPI_KIND_INTX = 2'h1,
      RPI_KIND_MSI  = 2'h2
   } rpi_kind_t;

endpackage : rpi_pkg

// ### rtl/rpi_msg_fifo.sv
`timescale 1ns/1ps
module rpi_msg_fifo
   import rpi_pkg::*;
#(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output logic                  full,
   output logic                  empty,
   output logic [WIDTH-1:0]      head
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             do_push;
   logic             do_pop;

   assign full    = (count == (AW+1)'(DEPTH));
   assign empty   = (count == '0);
   assign do_pop  = pop && !empty;
   assign do_push = push && (!full || do_pop);
   assign head    = mem[rd_ptr];

   always_ff @(posedge aclk) begin
      if (do_push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

endmodule : rpi_msg_fifo

// ### rtl/rpi_receiver.sv
`timescale 1ns/1ps
// What this block does
// RULE1: FIFO mode default; parameter selects decode mode
// RULE2: FIFO mode: INTx message sets decode bit 16
// RULE3: Interrupt out when bit 16 set and unmasked
// RULE4: Writes in 4 KB MSI window are MSI
// RULE5: FIFO mode: MSI sets bit 17, gated by mask
// RULE6: Status bit 18 shows FIFO not empty
// RULE7: Status bit 19 shows FIFO overflow
// RULE8: FIFO read 1 shows line and assert/deassert
// RULE9: FIFO read 2 shows head MSI data
// RULE10: Writing 1 to read-1 bit 31 pops head
// RULE11: Decode bits 16/17 clear only on write-1
// RULE12: Software rechecks lines after overflow
// RULE13: Decode mode: INTx assert sets masked line bit
// RULE14: Decode mode: INTx deassert clears line bit
// RULE15: Vector number is MSI data bits 5:0
// RULE16: Vector bits drive low or high output
// RULE17: MSI decode write-1 clears; mask gates outputs
// RULE18: Other writes forwarded after address translation
// RULE19: Interrupt outputs are level, set and unmasked
// RULE20: Full FIFO drops message, sticky overflow flag
// RULE21: Registers on AXI4-Lite slave, aclk, aresetn
module rpi_receiver
   import rpi_pkg::*;
#(
   parameter bit          DECODE_MODE = 1'b0,
   parameter int          FIFO_DEPTH  = 16,
   parameter logic [63:0] XLATE_BASE  = 64'h0000_0000_0000_0000
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite register slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Received link messages, one-cycle strobes
   input  wire logic        intx_valid,
   input  wire logic [1:0]  intx_line,
   input  wire logic        intx_assert,
   input  wire logic        mwr_valid,
   input  wire logic [63:0] mwr_addr,
   input  wire logic [31:0] mwr_data,
   // Forwarded writes toward the AXI master port
   output logic             fwd_valid,
   output logic [63:0]      fwd_addr,
   output logic [31:0]      fwd_data,
   // Interrupt outputs
   output logic             interrupt_out,
   output logic             msi_low_vector_irq,
   output logic             msi_high_vector_irq
);

   localparam int FW = 36;

   logic [31:0] decode;
   logic [31:0] mask;
   logic        overflow;
   logic [31:0] msi_base1;
   logic [31:0] msi_base2;
   logic [3:0]  decode2;
   logic [3:0]  decode2_mask;
   logic [31:0] msi_dec1;
   logic [31:0] msi_dec2;
   logic [31:0] msi_mask1;
   logic [31:0] msi_mask2;

   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic [31:0] wr_bits;

   logic        msi_hit;
   logic        msi_evt;
   logic        intx_evt;
   logic [5:0]  vec;
   logic        fifo_push;
   logic        fifo_pop;
   logic        fifo_full;
   logic        fifo_empty;
   logic [FW-1:0] fifo_head;
   logic [FW-1:0] push_word;

   // MSI window match on the upper address bits
   assign msi_hit  = mwr_valid && (mwr_addr[63:RPI_MSI_WIN_BITS] ==
                     {msi_base2, msi_base1[31:RPI_MSI_WIN_BITS]}); // RULE4
   assign msi_evt  = msi_hit;
   assign intx_evt = intx_valid;
   assign vec      = mwr_data[RPI_VEC_BITS-1:0]; // RULE15

   // Forwarding of non-MSI writes, MSI-X included
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fwd_valid <= 1'b0;
         fwd_addr  <= '0;
         fwd_data  <= '0;
      end else begin
         fwd_valid <= mwr_valid && !msi_hit; // RULE4 RULE18
         if (mwr_valid && !msi_hit) begin
            fwd_addr <= mwr_addr + XLATE_BASE; // RULE18
            fwd_data <= mwr_data;
         end
      end
   end

   // AXI4-Lite write channel capture
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign wr_go         = aw_held && w_held && !s_axi_bvalid;

   always_comb begin
      wr_bits = '0;
      for (int i = 0; i < 4; i++) begin
         if (w_strb[i]) begin
            wr_bits[i*8 +: 8] = w_data[i*8 +: 8];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RPI_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr <= RPI_OFF_MSI_MK2 && aw_addr[1:0] == 2'h0) ?
                            RPI_RESP_OKAY : RPI_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge aclk) begin // RULE21
      if (!aresetn) begin
         mask         <= RPI_RST_MASK;
         msi_base1    <= RPI_RST_ZERO;
         msi_base2    <= RPI_RST_ZERO;
         decode2_mask <= '0;
         msi_mask1    <= RPI_RST_MASK;
         msi_mask2    <= RPI_RST_MASK;
      end else if (wr_go) begin
         case (aw_addr)
            RPI_OFF_MASK:       mask         <= wr_bits; // RULE3
            RPI_OFF_MSI_BASE1:  msi_base1    <= wr_bits;
            RPI_OFF_MSI_BASE2:  msi_base2    <= wr_bits;
            RPI_OFF_DECODE2_MK: decode2_mask <= wr_bits[3:0];
            RPI_OFF_MSI_MK1:    msi_mask1    <= wr_bits; // RULE17
            RPI_OFF_MSI_MK2:    msi_mask2    <= wr_bits; // RULE17
            default:            mask         <= mask;
         endcase
      end
   end

   // FIFO mode decode bits: event set wins over write-1 clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         decode <= RPI_RST_ZERO;
      end else if (!DECODE_MODE) begin // RULE1
         if (wr_go && aw_addr == RPI_OFF_DECODE) begin
            decode <= decode & ~wr_bits; // RULE11
         end
         if (intx_evt) begin
            decode[RPI_BIT_INTX] <= 1'b1; // RULE2
         end
         if (msi_evt) begin
            decode[RPI_BIT_MSI] <= 1'b1; // RULE5
         end
      end
   end

   // FIFO queue of messages
   assign push_word = intx_evt ?
                      {2'(RPI_KIND_INTX), intx_assert, 1'b0, 32'(intx_line)} : // RULE8
                      {2'(RPI_KIND_MSI), 2'h0, mwr_data}; // RULE9
   assign fifo_push = !DECODE_MODE && (intx_evt || msi_evt);
   assign fifo_pop  = wr_go && aw_addr == RPI_OFF_FIFO_RD1 &&
                      w_strb[3] && w_data[RPI_BIT_POP]; // RULE10

   rpi_msg_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .push      (fifo_push),
      .push_data (push_word),
      .pop       (fifo_pop),
      .full      (fifo_full),
      .empty     (fifo_empty),
      .head      (fifo_head)
   );

   // Sticky overflow, cleared by write-1 to status bit 19
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow <= 1'b0;
      end else if (fifo_push && fifo_full && !fifo_pop) begin
         overflow <= 1'b1; // RULE20 RULE7
      end else if (wr_go && aw_addr == RPI_OFF_STATUS && wr_bits[RPI_BIT_OVERFLOW]) begin
         overflow <= 1'b0;
      end
   end

   // Decode mode line and vector state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         decode2  <= '0;
         msi_dec1 <= '0;
         msi_dec2 <= '0;
      end else if (DECODE_MODE) begin // RULE1
         if (wr_go && aw_addr == RPI_OFF_MSI_DEC1) begin
            msi_dec1 <= msi_dec1 & ~wr_bits; // RULE17
         end
         if (wr_go && aw_addr == RPI_OFF_MSI_DEC2) begin
            msi_dec2 <= msi_dec2 & ~wr_bits; // RULE17
         end
         if (intx_evt) begin
            decode2[intx_line] <= intx_assert; // RULE13 RULE14
         end
         if (msi_evt && !vec[5]) begin
            msi_dec1[vec[4:0]] <= 1'b1; // RULE16
         end
         if (msi_evt && vec[5]) begin
            msi_dec2[vec[4:0]] <= 1'b1; // RULE16
         end
      end
   end

   // Level interrupt outputs
   assign interrupt_out = (decode[RPI_BIT_INTX] && mask[RPI_BIT_INTX]) || // RULE3 RULE19
                          (decode[RPI_BIT_MSI] && mask[RPI_BIT_MSI]) || // RULE5
                          |(decode2 & decode2_mask); // RULE13
   assign msi_low_vector_irq  = |(msi_dec1 & msi_mask1); // RULE16 RULE19
   assign msi_high_vector_irq = |(msi_dec2 & msi_mask2); // RULE16

   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RPI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RPI_RESP_OKAY;
         case (s_axi_araddr)
            RPI_OFF_DECODE:     s_axi_rdata <= decode;
            RPI_OFF_MASK:       s_axi_rdata <= mask;
            RPI_OFF_STATUS:     s_axi_rdata <= {12'h000, overflow, !fifo_empty, 18'h00000}; // RULE6 RULE7
            RPI_OFF_FIFO_RD1:   s_axi_rdata <= fifo_empty ? '0 :
                                   {14'h0000, fifo_head[35:34] == 2'(RPI_KIND_MSI),
                                    fifo_head[33], 14'h0000, fifo_head[1:0]}; // RULE8
            RPI_OFF_FIFO_RD2:   s_axi_rdata <= fifo_empty ? '0 : fifo_head[31:0]; // RULE9
            RPI_OFF_MSI_BASE1:  s_axi_rdata <= msi_base1;
            RPI_OFF_MSI_BASE2:  s_axi_rdata <= msi_base2;
            RPI_OFF_DECODE2:    s_axi_rdata <= {28'h0000000, decode2};
            RPI_OFF_DECODE2_MK: s_axi_rdata <= {28'h0000000, decode2_mask};
            RPI_OFF_MSI_DEC1:   s_axi_rdata <= msi_dec1;
            RPI_OFF_MSI_DEC2:   s_axi_rdata <= msi_dec2;
            RPI_OFF_MSI_MK1:    s_axi_rdata <= msi_mask1;
            RPI_OFF_MSI_MK2:    s_axi_rdata <= msi_mask2;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RPI_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Assertions
   a_intx_sets_bit: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
      (!DECODE_MODE && intx_evt) |=> decode[RPI_BIT_INTX])
      else $error("INTx did not set decode bit 16");
   a_msi_sets_bit: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
      (!DECODE_MODE && msi_evt) |=> decode[RPI_BIT_MSI])
      else $error("MSI did not set decode bit 17");
   a_irq_out_level: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
      (decode[RPI_BIT_INTX] && mask[RPI_BIT_INTX]) |-> interrupt_out)
      else $error("interrupt_out low while INTx pending and unmasked");
   a_window_no_fwd: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
      msi_hit |=> !fwd_valid)
      else $error("MSI window write forwarded");
   a_fwd_outside: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
      (mwr_valid && !msi_hit) |=> (fwd_valid && fwd_data == $past(mwr_data)))
      else $error("Write outside MSI window not forwarded");
   a_empty_status: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == RPI_OFF_STATUS)
      |=> s_axi_rdata[RPI_BIT_NOT_EMPTY] == !$past(fifo_empty))
      else $error("Status not-empty bit wrong");
   a_overflow_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
      (overflow && !(wr_go && aw_addr == RPI_OFF_STATUS)) |=> overflow)
      else $error("Overflow flag dropped without clear");
   a_decode_no_zclr: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
      (decode[RPI_BIT_INTX] && !(wr_go && aw_addr == RPI_OFF_DECODE)) |=> decode[RPI_BIT_INTX])
      else $error("Decode bit 16 cleared without write-1");
   a_deassert_clears: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
      (DECODE_MODE && intx_evt && !intx_assert) |=> !decode2[$past(intx_line)])
      else $error("INTx deassert did not clear line");
   a_vec_high_irq: assert property (@(posedge aclk) disable iff (!aresetn) // RULE16
      (DECODE_MODE && msi_evt && vec[5] && msi_mask2[vec[4:0]]) |=> msi_high_vector_irq)
      else $error("High vector output not asserted");

endmodule : rpi_receiver

// ### testbench/rpi_link_model.sv
`timescale 1ns/1ps
module rpi_link_model (
   input  wire logic   aclk,
   output logic        intx_valid,
   output logic [1:0]  intx_line,
   output logic        intx_assert,
   output logic        mwr_valid,
   output logic [63:0] mwr_addr,
   output logic [31:0] mwr_data
);
   initial begin
      {intx_valid, intx_line, intx_assert} = 4'h0;
      {mwr_valid, mwr_addr, mwr_data} = 97'h0;
   end
   // One-cycle strobe after gap+1 idle cycles; released payload inverted
   task automatic send_intx(input logic [1:0] l, input logic a, input int gap);
      repeat (gap + 1) @(posedge aclk);
      intx_valid  <= 1'b1;
      intx_line   <= l;
      intx_assert <= a;
      @(posedge aclk);
      intx_valid  <= 1'b0;
      intx_line   <= ~l;
      intx_assert <= ~a;
   endtask : send_intx
   task automatic send_mwr(input logic [63:0] ad, input logic [31:0] d, input int gap);
      repeat (gap + 1) @(posedge aclk);
      mwr_valid <= 1'b1;
      mwr_addr  <= ad;
      mwr_data  <= d;
      @(posedge aclk);
      mwr_valid <= 1'b0;
      mwr_addr  <= ~ad;
      mwr_data  <= ~d;
   endtask : send_mwr
endmodule : rpi_link_model

// ### testbench/root_port_interrupt_receiver_test.sv
`timescale 1ns/1ps
module root_port_interrupt_receiver_test
   import rpi_pkg::*;
;
   localparam int          DEPTH = 4;
   localparam logic [63:0] XLATE = 64'h0000_0010_0000_0000;
   localparam logic [63:0] BASE  = 64'h0000_0001_8000_0000;
   logic        aclk = 1'b0;
   logic        aresetn, awvalid, wvalid, bready, arvalid, rready, m_ovf;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, mwr_data, m_dec, m_mask, m_mask2, m_vm1, m_vm2;
   int          sel, seed = 893, err_total = 0, compares = 0, cycles = 0;
   logic [1:0]  awready, wready, bvalid, arready, rvalid, fwd_valid, irq, lo, hi;
   logic [1:0]  bresp [2], rresp [2], intx_line;
   logic [31:0] rdata [2], fwd_data [2];
   logic [63:0] fwd_addr [2], mwr_addr, m_vec;
   logic        intx_valid, intx_assert, mwr_valid;
   logic [3:0]  m_d2;
   logic [63:0] m_q [$];
   logic [95:0] fq0 [$], fq1 [$], fe;

   always #2.5 aclk = ~aclk;

   rpi_link_model rpi_link_model_inst (.aclk(aclk), .intx_valid(intx_valid),
      .intx_line(intx_line), .intx_assert(intx_assert), .mwr_valid(mwr_valid),
      .mwr_addr(mwr_addr), .mwr_data(mwr_data));

   // Instance 0 in FIFO mode, instance 1 in decode mode; link traffic shared
   for (genvar g = 0; g < 2; g++) begin : g_dut
      rpi_receiver #(.DECODE_MODE(g == 1), .FIFO_DEPTH(DEPTH), .XLATE_BASE(XLATE))
      rpi_receiver_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
         .s_axi_awvalid(awvalid && sel == g), .s_axi_awready(awready[g]),
         .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid && sel == g),
         .s_axi_wready(wready[g]), .s_axi_bresp(bresp[g]), .s_axi_bvalid(bvalid[g]),
         .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid && sel == g),
         .s_axi_arready(arready[g]), .s_axi_rdata(rdata[g]), .s_axi_rresp(rresp[g]),
         .s_axi_rvalid(rvalid[g]), .s_axi_rready(rready), .intx_valid(intx_valid),
         .intx_line(intx_line), .intx_assert(intx_assert), .mwr_valid(mwr_valid),
         .mwr_addr(mwr_addr), .mwr_data(mwr_data), .fwd_valid(fwd_valid[g]),
         .fwd_addr(fwd_addr[g]), .fwd_data(fwd_data[g]), .interrupt_out(irq[g]),
         .msi_low_vector_irq(lo[g]), .msi_high_vector_irq(hi[g]));
   end

   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   always @(posedge aclk) begin
      cycles++;
      if (fwd_valid[0] === 1'b1) begin
         fe = fq0.size() ? fq0.pop_front() : ~{fwd_addr[0], fwd_data[0]};
         check("fwd_fifo", {fwd_addr[0], fwd_data[0]}, fe);
      end
      if (fwd_valid[1] === 1'b1) begin
         fe = fq1.size() ? fq1.pop_front() : ~{fwd_addr[1], fwd_data[1]};
         check("fwd_dec", {fwd_addr[1], fwd_data[1]}, fe);
      end
      if (cycles == 40000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic wr(input int s, input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      sel     <= s;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready[s]) awvalid <= 1'b0;
         if (wvalid && wready[s]) wvalid <= 1'b0;
         if (bvalid[s] === 1'b1) begin
            r = bresp[s];
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : wr

   task automatic rd(input int s, input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      sel     <= s;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready[s]) arvalid <= 1'b0;
         if (rvalid[s] === 1'b1) begin
            d = rdata[s];
            r = rresp[s];
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : rd

   task automatic push(input logic [63:0] e);
      if (m_q.size() < DEPTH) m_q.push_back(e);
      else m_ovf = 1'b1;
   endtask : push

   task automatic ev_intx(input logic [1:0] l, input logic a, input int gap);
      m_dec[RPI_BIT_INTX] = 1'b1;
      push({32'h0, 14'h0, 1'b0, a, 14'h0, l});
      m_d2[l] = a;
      rpi_link_model_inst.send_intx(l, a, gap);
   endtask : ev_intx

   task automatic ev_mwr(input logic [63:0] ad, input logic [31:0] d, input int gap);
      if (ad[63:12] == BASE[63:12]) begin
         m_dec[RPI_BIT_MSI] = 1'b1;
         push({d, 32'h0002_0000});
         m_vec[d[5:0]] = 1'b1;
      end else begin
         fq0.push_back({ad + XLATE, d});
         fq1.push_back({ad + XLATE, d});
      end
      rpi_link_model_inst.send_mwr(ad, d, gap);
   endtask : ev_mwr

   task automatic pop_n(input int n);
      logic [1:0] r;
      repeat (n) if (m_q.size() != 0) begin
         wr(0, RPI_OFF_FIFO_RD1, 32'h8000_0000, r);
         void'(m_q.pop_front());
      end
   endtask : pop_n

   task automatic check_all();
      logic [31:0] d;
      logic [1:0]  r;
      logic [63:0] h;
      repeat (3) @(posedge aclk);
      h = m_q.size() ? m_q[0] : 64'h0;
      rd(0, RPI_OFF_DECODE, d, r);
      check("decode", d & 32'h0003_0000, m_dec);
      rd(0, RPI_OFF_STATUS, d, r);
      check("status", d & 32'h000c_0000, {12'h0, m_ovf, (m_q.size() != 0), 18'h0});
      rd(0, RPI_OFF_FIFO_RD1, d, r);
      check("fifo_rd1", d & (h[17] ? 32'h0003_0000 : 32'h0003_0003), h[31:0]);
      rd(0, RPI_OFF_FIFO_RD2, d, r);
      if (h[17] || m_q.size() == 0) check("fifo_rd2", d, h[63:32]);
      check("irq_fifo", irq[0], |(m_dec & m_mask));
      check("vec_fifo", {lo[0], hi[0]}, 2'h0);
      rd(1, RPI_OFF_DECODE2, d, r);
      check("decode2", d & 32'hf, m_d2);
      rd(1, RPI_OFF_MSI_DEC1, d, r);
      check("msi_dec1", d, m_vec[31:0]);
      rd(1, RPI_OFF_MSI_DEC2, d, r);
      check("msi_dec2", d, m_vec[63:32]);
      check("irq_dec", irq[1], |(m_d2 & m_mask2[3:0]));
      check("msi_lo", lo[1], |(m_vec[31:0] & m_vm1));
      check("msi_hi", hi[1], |(m_vec[63:32] & m_vm2));
   endtask : check_all

   initial begin
      logic [31:0] r, d;
      logic [1:0]  rs;
      logic [63:0] ah, am;
      {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h0;
      {awaddr, araddr, wdata, sel} = 80'h0;
      {m_dec, m_mask, m_mask2, m_vm1, m_vm2, m_d2, m_vec, m_ovf} = 229'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (int s = 0; s < 2; s++) begin
         for (int a = 0; a <= 'h30; a += 4) begin
            rd(s, 8'(a), d, rs);
            check("reset_val", {rs, d}, {RPI_RESP_OKAY, RPI_RST_ZERO});
         end
         wr(s, RPI_OFF_MSI_BASE1, BASE[31:0], rs);
         wr(s, RPI_OFF_MSI_BASE2, BASE[63:32], rs);
      end
      check("reset_outs", {irq, lo, hi, fwd_valid}, 8'h0);
      wr(0, 8'h40, 32'h1, rs);
      check("unmapped_wr", rs, RPI_RESP_SLVERR);
      rd(1, 8'h40, d, rs);
      check("unmapped_rd", {rs, d}, {RPI_RESP_SLVERR, 32'h0});
      $display("test registers done");
      // Zero-gap burst one past the FIFO depth
      for (int i = 0; i <= DEPTH; i++) ev_mwr({BASE[63:12], 12'(i * 4)}, $random(seed), 0);
      check_all();
      $display("test burst done");
      repeat (150) begin
         r = $random(seed);
         ah = {BASE[63:12], r[5] ? {12{r[3]}} : r[31:20]};
         am = r[5] ? (r[3] ? BASE + 64'h1000 : BASE - 64'h1) : {$random(seed), r};
         case (r[2:0])
            3'h0: ev_intx(r[4:3], r[6], r[9:8]);
            3'h1: ev_mwr(ah, $random(seed), r[9:8]);
            3'h2: ev_mwr(am | 64'h4000_0000_0000_0000 * !r[5], $random(seed), r[9:8]);
            3'h3: pop_n(2);
            3'h4: begin
               wr(0, RPI_OFF_DECODE, r & 32'h0003_0000, rs);
               m_dec &= ~(r & 32'h0003_0000);
            end
            3'h5: begin
               m_mask  = r & 32'h0003_0000;
               m_mask2 = r & 32'hf;
               m_vm1   = $random(seed);
               m_vm2   = $random(seed);
               wr(0, RPI_OFF_MASK, m_mask, rs);
               wr(1, RPI_OFF_DECODE2_MK, m_mask2, rs);
               wr(1, RPI_OFF_MSI_MK1, m_vm1, rs);
               wr(1, RPI_OFF_MSI_MK2, m_vm2, rs);
            end
            3'h6: begin
               d = $random(seed);
               wr(1, RPI_OFF_MSI_DEC1, d, rs);
               wr(1, RPI_OFF_MSI_DEC2, r, rs);
               m_vec &= ~{r, d};
            end
            default: begin
               pop_n(DEPTH);
               wr(0, RPI_OFF_STATUS, 32'h0008_0000, rs);
               m_ovf = 1'b0;
            end
         endcase
         check_all();
      end
      check("fwd_left", fq0.size() + fq1.size(), 0);
      $display("test random done");
      complete_run();
   end
endmodule : root_port_interrupt_receiver_test
